// ### rtl/buck_ctrl_consts.vh
// constants for the step-down converter control logic
`ifndef BUCK_CTRL_CONSTS_VH
`define BUCK_CTRL_CONSTS_VH

// ============================================================
// clock and timing
// ============================================================
`define CLK_FREQ_KHZ 125000
`define CLK_PERIOD_NS 8
// oscillator cycle of the fixed-frequency mode
`define PWM_FREQ_KHZ 4300
`define PWM_PERIOD_CYC (`CLK_FREQ_KHZ / `PWM_FREQ_KHZ)
// divide ratio used while the output is shorted
`define SLOW_DIVIDE 8
// non-overlap gap between the two switch commands
`define DEAD_TIME_NS 16
`define DEAD_CYC ((`DEAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// settling time granted to the reference after wake-up
`define REF_WAKE_NS 10000
`define REF_WAKE_CYC (`REF_WAKE_NS / `CLK_PERIOD_NS)
// soft-start ramp duration
`define SOFT_START_US 1000
`define SOFT_START_CYC (`SOFT_START_US * 1000 / `CLK_PERIOD_NS)

// ============================================================
// light-load mode entry and soft-start ramp width
// ============================================================
`define ZC_ENTRY_COUNT 16
`define RAMP_BITS 10

// ============================================================
// register map (byte addresses)
// ============================================================
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_RAMP 4'h8
`define CTRL_RESET 1'h0
`define CTRL_FORCE_PWM_BIT 0

`endif

// ### rtl/sync_bank.v
// two-flop synchroniser bank for asynchronous comparator flags
module sync_bank #(
  parameter WIDTH = 8
) (
  input wire core_clk,
  input wire rst_n,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  // ============================================================
  // one two-stage chain per flag
  // ============================================================
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      reg meta_q; // first stage, read only by the second
      reg hold_q; // second stage, safe to use
      always @(posedge core_clk)
      begin
        if (!rst_n)
        begin
          meta_q <= 1'h0;
          hold_q <= 1'h0;
        end
        else
        begin
          meta_q <= async_in[i];
          hold_q <= meta_q;
        end
      end
      assign sync_out[i] = hold_q;
    end
  endgenerate

endmodule // sync_bank

// ### rtl/buck_pwm_skip_controller.v
// switch sequencing, light-load skip mode and protection for a buck stage
//
// Chosen here: the register offsets and the strobed register port.
`include "buck_ctrl_consts.vh"

// Behaviour
// - high-side on at each pwm cycle start
// - current trip: high off, low on till end
// - sixteen zero-cross cycles enter skip mode
// - cycle without zero cross clears counter
// - skip pulses clock aligned, end at skip trip
// - output high in skip: off, then idle
// - output back at nominal resumes pulses
// - output low leaves skip for pwm
// - enable wakes reference before soft-start
// - disable: switches off, discharge path on
// - overcurrent turns high-side off at once
// - short circuit selects slow oscillator
// - supply lockout holds converter disabled
// - ramp reference only during start-up
// - dropout keeps high-side fully on in pwm mode
// - overtemperature shutdown, restart via soft-start
module buck_pwm_skip_controller #(
  parameter SS_CYCLES = `SOFT_START_CYC // shorten for simulation
) (
  input wire core_clk,
  input wire rst_n,
  input wire enable_pin,
  input wire low_supply_lockout,
  input wire overtemp_flag,
  input wire pwm_trip,
  input wire overcurrent_trip,
  input wire skip_trip,
  input wire zero_cross,
  input wire output_high,
  input wire output_nominal,
  input wire output_low,
  input wire short_circuit_detector,
  input wire dropout_flag,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  output reg high_side_on,
  output reg low_side_on,
  output reg discharge_on,
  output reg ref_wake,
  output reg soft_start_active,
  output reg [9:0] ramp_ref,
  output reg osc_slow
);

  // ============================================================
  // constants
  // ============================================================
  // counts worked out at full width, then cut to their registers
  localparam integer FAST_INT = `PWM_PERIOD_CYC;
  localparam integer SLOW_INT = `PWM_PERIOD_CYC * `SLOW_DIVIDE;
  localparam integer DEAD_INT = `DEAD_CYC;
  localparam integer WAKE_INT = `REF_WAKE_CYC;
  localparam integer ZC_INT = `ZC_ENTRY_COUNT;
  localparam [7:0] FAST_PER = FAST_INT[7:0];
  localparam [7:0] SLOW_PER = SLOW_INT[7:0];
  localparam [1:0] DEAD = DEAD_INT[1:0];
  localparam [10:0] WAKE_CYC = WAKE_INT[10:0];
  localparam [4:0] ZC_MAX = ZC_INT[4:0];
  // cycles per ramp step, never below one
  localparam integer STEP_RAW = SS_CYCLES / (1 << `RAMP_BITS);
  localparam integer STEP_INT = (STEP_RAW < 1) ? 1 : STEP_RAW;
  localparam [16:0] STEP_CYC = STEP_INT[16:0];
  // supervisor states
  localparam [2:0] ST_OFF = 3'h0;
  localparam [2:0] ST_WAKE = 3'h1;
  localparam [2:0] ST_SOFT = 3'h2;
  localparam [2:0] ST_RUN = 3'h3;
  localparam [2:0] ST_HOT = 3'h4;

  // ============================================================
  // synchronised comparator flags
  // ============================================================
  wire [11:0] raw_flags; // every flag from the analog side
  wire [11:0] flags; // the same, after two flops
  assign raw_flags = {dropout_flag, short_circuit_detector, output_low,
    output_nominal, output_high, zero_cross, skip_trip, overcurrent_trip,
    pwm_trip, overtemp_flag, low_supply_lockout, enable_pin};

  sync_bank #(
    .WIDTH(12)
  ) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(raw_flags),
    .sync_out(flags)
  );

  wire en_s = flags[0];
  wire low_supply_lockout_s = flags[1];
  wire hot_s = flags[2];
  wire pwm_s = flags[3];
  wire oc_s = flags[4];
  wire skip_s = flags[5];
  wire zc_s = flags[6];
  wire high_s = flags[7];
  wire nom_s = flags[8];
  wire low_s = flags[9];
  wire scp_s = flags[10];
  wire drop_s = flags[11];

  // ============================================================
  // state
  // ============================================================
  reg [2:0] state_q; // supervisor state
  reg [16:0] timer_q; // wake timer and ramp step timer
  reg [7:0] phase_q; // position inside the oscillator cycle
  reg hs_req_q; // high-side wanted this cycle
  reg ls_req_q; // low-side wanted this cycle
  reg [1:0] dead_q; // non-overlap countdown
  reg skip_q; // light-load mode active
  reg idle_q; // skip mode parked at zero current
  reg zc_seen_q; // a zero cross was seen this cycle
  reg [4:0] zc_cnt_q; // consecutive zero-cross cycles
  reg force_pwm_q; // software block on skip-mode entry; skip already active stays

  wire running = (state_q == ST_SOFT) || (state_q == ST_RUN);
  wire [7:0] period = osc_slow ? SLOW_PER : FAST_PER;
  wire cycle_end = (phase_q >= period - 8'h1);
  wire zc_now = zc_seen_q | zc_s;

  // ============================================================
  // register port
  // ============================================================
  // the control register steers mode selection
  always @(posedge core_clk)
  begin
    if (!rst_n)
      force_pwm_q <= `CTRL_RESET;
    else if (reg_wr && reg_addr == `REG_CTRL)
      force_pwm_q <= reg_wdata[`CTRL_FORCE_PWM_BIT];
  end

  // read data in the cycle after the strobe, zero otherwise
  always @(posedge core_clk)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0;
    else if (reg_rd)
    begin
      case (reg_addr)
        `REG_CTRL: reg_rdata <= {31'h0, force_pwm_q};
        `REG_STATUS: reg_rdata <= {20'h0, zc_cnt_q, drop_s, osc_slow,
          idle_q, skip_q, state_q};
        `REG_RAMP: reg_rdata <= {22'h0, ramp_ref};
        default: reg_rdata <= 32'h0; // unmapped reads as zero
      endcase
    end
    else
      reg_rdata <= 32'h0;
  end

  // ============================================================
  // supervisor: enable, lockout, reference, soft-start, thermal
  // ============================================================
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state_q <= ST_OFF;
      timer_q <= 17'h0;
      ramp_ref <= 10'h0;
    end
    else if (!en_s || low_supply_lockout_s)
    begin
      // disabled or starved supply: everything back to rest
      state_q <= ST_OFF;
      timer_q <= 17'h0;
      ramp_ref <= 10'h0;
    end
    else
    begin
      case (state_q)
        ST_OFF:
        begin
          // reference first, switching only later
          if (!hot_s)
            state_q <= ST_WAKE;
          timer_q <= 17'h0;
        end
        ST_WAKE:
        begin
          if (timer_q[10:0] >= WAKE_CYC - 11'h1)
          begin
            state_q <= ST_SOFT;
            timer_q <= 17'h0;
          end
          else
            timer_q <= timer_q + 17'h1;
        end
        ST_SOFT:
        begin
          if (hot_s)
            state_q <= ST_HOT;
          else if (timer_q >= STEP_CYC - 17'h1)
          begin
            // one ramp step; full scale ends start-up
            timer_q <= 17'h0;
            if (ramp_ref == 10'h3FF)
              state_q <= ST_RUN;
            else
              ramp_ref <= ramp_ref + 10'h1;
          end
          else
            timer_q <= timer_q + 17'h1;
        end
        ST_RUN:
        begin
          if (hot_s)
            state_q <= ST_HOT;
        end
        ST_HOT:
        begin
          // restart from an empty ramp once cooled down
          ramp_ref <= 10'h0;
          timer_q <= 17'h0;
          if (!hot_s)
            state_q <= ST_SOFT;
        end
        default:
          state_q <= ST_OFF;
      endcase
    end
  end

  // ============================================================
  // status outputs of the supervisor
  // ============================================================
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      discharge_on <= 1'h0;
      ref_wake <= 1'h0;
      soft_start_active <= 1'h0;
      osc_slow <= 1'h0;
    end
    else
    begin
      discharge_on <= !en_s;
      ref_wake <= en_s && !low_supply_lockout_s && (state_q != ST_OFF);
      // ramp drives the loops only while starting
      soft_start_active <= (state_q == ST_SOFT);
      osc_slow <= scp_s;
    end
  end

  // ============================================================
  // oscillator
  // ============================================================
  // a change of period takes effect at once; the compare is
  // greater-or-equal so a shortened period never overruns
  always @(posedge core_clk)
  begin
    if (!rst_n || !running)
      phase_q <= 8'h0;
    else if (cycle_end)
      phase_q <= 8'h0;
    else
      phase_q <= phase_q + 8'h1;
  end

  // ============================================================
  // zero-cross counter and mode selection
  // ============================================================
  always @(posedge core_clk)
  begin
    if (!rst_n || !running)
    begin
      zc_seen_q <= 1'h0;
      zc_cnt_q <= 5'h0;
      skip_q <= 1'h0;
      idle_q <= 1'h0;
    end
    else
    begin
      zc_seen_q <= cycle_end ? 1'h0 : zc_now;
      if (skip_q)
      begin
        zc_cnt_q <= 5'h0;
        if (low_s)
        begin
          // output sagging: back to fixed frequency
          skip_q <= 1'h0;
          idle_q <= 1'h0;
        end
        else if (high_s)
          idle_q <= 1'h1;
        else if (nom_s)
          idle_q <= 1'h0;
      end
      else if (cycle_end && state_q == ST_RUN)
      begin
        if (!zc_now)
          zc_cnt_q <= 5'h0;
        else if (zc_cnt_q + 5'h1 >= ZC_MAX && !force_pwm_q)
        begin
          skip_q <= 1'h1;
          zc_cnt_q <= 5'h0;
        end
        else if (zc_cnt_q + 5'h1 < ZC_MAX)
          zc_cnt_q <= zc_cnt_q + 5'h1;
      end
    end
  end

  // ============================================================
  // per-cycle switch requests
  // ============================================================
  always @(posedge core_clk)
  begin
    if (!rst_n || !running)
    begin
      hs_req_q <= 1'h0;
      ls_req_q <= 1'h0;
    end
    else if (cycle_end)
    begin
      if (!skip_q)
      begin
        // fixed frequency: every cycle opens with the high side
        hs_req_q <= 1'h1;
        ls_req_q <= 1'h0;
      end
      else if (!idle_q && !high_s)
      begin
        // skip pulses still start on the clock
        hs_req_q <= 1'h1;
        ls_req_q <= 1'h0;
      end
      else
        hs_req_q <= 1'h0; // parked: no new pulse
    end
    else if (hs_req_q && oc_s)
    begin
      // current limit beats every request except the new-cycle one at cycle_end
      hs_req_q <= 1'h0;
      ls_req_q <= 1'h1;
    end
    else if (!skip_q)
    begin
      // dropout ignores the current comparator
      if (hs_req_q && pwm_s && !drop_s)
      begin
        hs_req_q <= 1'h0;
        ls_req_q <= 1'h1;
      end
      else if (drop_s && !oc_s)
      begin
        hs_req_q <= 1'h1;
        ls_req_q <= 1'h0;
      end
    end
    else if (hs_req_q && (skip_s || high_s))
    begin
      hs_req_q <= 1'h0;
      ls_req_q <= 1'h1;
    end
    else if (ls_req_q && zc_s)
      ls_req_q <= 1'h0;
  end

  // ============================================================
  // gate drive with non-overlap
  // ============================================================
  // both commands come from one decision, so they can never be
  // on together; a change always passes through an all-off gap
  always @(posedge core_clk)
  begin
    if (!rst_n || !running)
    begin
      high_side_on <= 1'h0;
      low_side_on <= 1'h0;
      dead_q <= 2'h0;
    end
    // overcurrent cuts the gate itself, one edge ahead of the request
    else if ((high_side_on && (!hs_req_q || oc_s)) ||
      (low_side_on && !ls_req_q))
    begin
      high_side_on <= 1'h0;
      low_side_on <= 1'h0;
      dead_q <= DEAD;
    end
    else if (dead_q != 2'h0)
      dead_q <= dead_q - 2'h1;
    else if (!high_side_on && !low_side_on)
    begin
      high_side_on <= hs_req_q && !oc_s;
      low_side_on <= ls_req_q && !hs_req_q;
    end
  end

endmodule // buck_pwm_skip_controller

// ### tb/buck_ctrl_checker.sv
// port-level assertion checker for the buck switch controller
module buck_ctrl_checker (
  input wire core_clk,
  input wire rst_n,
  input wire enable_pin,
  input wire low_supply_lockout,
  input wire overtemp_flag,
  input wire overcurrent_trip,
  input wire high_side_on,
  input wire low_side_on,
  input wire discharge_on,
  input wire ref_wake,
  input wire soft_start_active,
  input wire [9:0] ramp_ref
);
  timeunit 1ns;
  timeprecision 1ps;
  // ============================================================
  // one clock domain: reset masks every check
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ============================================================
  // switch command safety
  property p_no_overlap; !(high_side_on && low_side_on); endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("both switch commands on");
  // low-side must wait out the dead gap after the high-side drops
  property p_gap; $fell(high_side_on) |-> !low_side_on [*2]; endproperty
  a_gap: assert property (p_gap)
    else $error("low side on inside dead gap");
  // ============================================================
  // enable, lockout and thermal paths (pin to gate takes 4 edges)
  property p_off; !enable_pin [*4] |=> !high_side_on && !low_side_on
    && discharge_on; endproperty
  a_off: assert property (p_off)
    else $error("disabled but switching or no discharge");
  property p_dis_rel; enable_pin [*4] |=> !discharge_on; endproperty
  a_dis_rel: assert property (p_dis_rel)
    else $error("discharge on while enabled");
  property p_lock; low_supply_lockout [*4] |=> !high_side_on
    && !low_side_on && !soft_start_active; endproperty
  a_lock: assert property (p_lock)
    else $error("active during supply lockout");
  property p_hot; overtemp_flag [*4] |=> !high_side_on
    && !low_side_on; endproperty
  a_hot: assert property (p_hot)
    else $error("switching while over temperature");
  // overcurrent has only the synchroniser delay to act in
  property p_ocp; $rose(overcurrent_trip) |-> ##[1:3] !high_side_on;
  endproperty
  a_ocp: assert property (p_ocp)
    else $error("high side not dropped on overcurrent");
  // ============================================================
  // start-up sequence
  property p_ref_first; $rose(ref_wake) |-> !soft_start_active [*8];
  endproperty
  a_ref_first: assert property (p_ref_first)
    else $error("soft start without reference settling");
  property p_ramp; ramp_ref > $past(ramp_ref) |-> soft_start_active;
  endproperty
  a_ramp: assert property (p_ramp)
    else $error("ramp rising outside soft start");
endmodule // buck_ctrl_checker

bind buck_pwm_skip_controller buck_ctrl_checker i_buck_ctrl_checker (
  .core_clk, .rst_n, .enable_pin, .low_supply_lockout, .overtemp_flag,
  .overcurrent_trip, .high_side_on, .low_side_on, .discharge_on,
  .ref_wake, .soft_start_active, .ramp_ref);

// ### tb/power_stage_model.sv
// behavioural model of the current comparators around the power switches
module power_stage_model (
  input wire core_clk,
  input wire high_side_on,
  input wire low_side_on,
  input wire zc_en,
  output logic pwm_trip,
  output logic skip_trip,
  output logic zero_cross
);
  timeunit 1ns;
  timeprecision 1ps;
  // ============================================================
  // current proxies: cycles spent with each switch on
  int hs_cnt = 0;
  int ls_cnt = 0;
  // current ramps while high-side conducts, decays on the low-side
  always @(posedge core_clk)
  begin
    hs_cnt <= high_side_on ? hs_cnt + 1 : 0;
    ls_cnt <= low_side_on ? ls_cnt + 1 : 0;
  end
  // skip level is reached well before the control reference
  assign skip_trip = hs_cnt >= 2;
  assign pwm_trip = hs_cnt >= 6;
  // light load: inductor current crosses zero early in the off phase
  assign zero_cross = zc_en && ls_cnt >= 3;
endmodule // power_stage_model

// ### tb/tb_top.sv
// self-checking bench for the buck switch controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ============================================================
  // stimulus, observed outputs and tallies
  logic core_clk, rst_n, enable_pin, low_supply_lockout, overtemp_flag;
  logic overcurrent_trip, output_high, output_nominal, output_low;
  logic short_circuit_detector, dropout_flag, reg_wr, reg_rd, zc_en;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, d;
  wire [31:0] reg_rdata;
  wire [9:0] ramp_ref;
  wire pwm_trip, skip_trip, zero_cross, high_side_on, low_side_on;
  wire discharge_on, ref_wake, soft_start_active, osc_slow;
  int error_cnt = 0, checks = 0, hs_rises = 0, ls_rises = 0;
  int hs_hi = 0, hs_lo = 0;
  logic hs_prev = 1'h0, ls_prev = 1'h0;
  // short soft start keeps the run brief (ramp step of 2 cycles)
  buck_pwm_skip_controller #(.SS_CYCLES(2048))
  i_buck_pwm_skip_controller (
    .core_clk, .rst_n, .enable_pin, .low_supply_lockout, .overtemp_flag,
    .pwm_trip, .overcurrent_trip, .skip_trip, .zero_cross, .output_high,
    .output_nominal, .output_low, .short_circuit_detector, .dropout_flag,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .high_side_on,
    .low_side_on, .discharge_on, .ref_wake, .soft_start_active,
    .ramp_ref, .osc_slow);
  power_stage_model i_power_stage_model (
    .core_clk, .high_side_on, .low_side_on, .zc_en, .pwm_trip,
    .skip_trip, .zero_cross);
  // ============================================================
  // clock and gate activity counters (negedge: values are settled)
  initial
  begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end
  always @(negedge core_clk)
  begin
    hs_rises += high_side_on & ~hs_prev;
    ls_rises += low_side_on & ~ls_prev;
    hs_hi += high_side_on;
    hs_lo += !high_side_on;
    hs_prev = high_side_on;
    ls_prev = low_side_on;
  end
  // ============================================================
  // helpers
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'h1;
    step(1);
    reg_wr <= 1'h0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_rd <= 1'h1;
    step(1);
    reg_rd <= 1'h0;
    #1 v = reg_rdata;
    step(1);
  endtask
  // poll the state field, bounded
  task automatic wait_state(input logic [2:0] s, input int lim);
    d = 32'hFFFFFFFF;
    for (int n = 0; n < lim && d[2:0] !== s; n++)
      rd(4'h4, d);
    chk("state", d[2:0], s);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // a hang counts as a failure
  initial
  begin
    step(20000);
    error_cnt++;
    $display("Error watchdog expected finish seen hang");
    summarize();
  end
  // ============================================================
  // test sequence
  initial
  begin
    {rst_n, enable_pin, low_supply_lockout, overtemp_flag} = 4'h0;
    {overcurrent_trip, output_high, output_nominal, output_low} = 4'h0;
    {short_circuit_detector, dropout_flag, reg_wr, reg_rd} = 4'h0;
    zc_en = 1'h0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    step(3);
    rst_n <= 1'h1;
    step(4);
    // registers: reset values, read-only status, unmapped place
    rd(4'h4, d); chk("status", d, 32'h0);
    wr(4'h4, 32'hFF); rd(4'h4, d); chk("status ro", d, 32'h0);
    rd(4'hC, d); chk("unmapped", d, 32'h0);
    rd(4'h0, d); chk("ctrl", d, 32'h0);
    wr(4'h0, 32'h1); rd(4'h0, d); chk("ctrl wr", d, 32'h1);
    wr(4'h0, 32'h0); chk("rdata idle", reg_rdata, 32'h0);
    chk("discharge", discharge_on, 1'h1);
    $display("test registers done");
    // start-up: reference first, then ramp, then run
    enable_pin <= 1'h1;
    wait_state(3'h1, 20);
    chk("ref", ref_wake, 1'h1);
    chk("ss early", soft_start_active, 1'h0);
    wait_state(3'h2, 700);
    chk("ss", soft_start_active, 1'h1);
    wait_state(3'h3, 1200);
    chk("ramp end", ramp_ref, 10'h3FF);
    chk("ss off", soft_start_active, 1'h0);
    $display("test start-up done");
    // pwm: one pulse per 29-cycle period, low-side after each trip
    {hs_rises, ls_rises, hs_hi} = 0; step(290);
    chk("pwm pulses", hs_rises, 10);
    chk("ls pulses", ls_rises, 10);
    chk("pwm width", hs_hi > 70, 1'h1);
    // zero-cross run broken before sixteen clears the count
    zc_en <= 1'h1; step(290); zc_en <= 1'h0; step(87);
    rd(4'h4, d); chk("zc clear", d[11:3], 9'h0);
    // forced pwm holds the count at fifteen, release enters skip
    wr(4'h0, 32'h1); zc_en <= 1'h1; step(580);
    rd(4'h4, d); chk("forced pwm", d[11:3], 9'h0F0);
    wr(4'h0, 32'h0); step(58);
    rd(4'h4, d); chk("skip", d[3], 1'h1);
    {hs_rises, hs_hi} = 0; step(290);
    chk("skip pulses", hs_rises, 10);
    chk("skip width", hs_hi < 70, 1'h1);
    // output high idles, nominal resumes, low leaves skip
    output_high <= 1'h1; step(10); rd(4'h4, d);
    chk("idle", d[4], 1'h1);
    hs_rises = 0; step(100); chk("idle hs", hs_rises, 0);
    output_high <= 1'h0; output_nominal <= 1'h1; step(10);
    hs_rises = 0; step(60); output_nominal <= 1'h0;
    chk("resume", hs_rises > 0, 1'h1);
    zc_en <= 1'h0; output_low <= 1'h1; step(10); output_low <= 1'h0;
    rd(4'h4, d); chk("pwm back", d[4:3], 2'h0);
    $display("test skip done");
    // short circuit: slow oscillator, 8x period
    short_circuit_detector <= 1'h1; step(6);
    chk("slow", osc_slow, 1'h1);
    hs_rises = 0; step(464);
    chk("slow pulses", hs_rises inside {[1:3]}, 1'h1);
    short_circuit_detector <= 1'h0;
    // dropout holds the high-side on; overcurrent still cuts it
    dropout_flag <= 1'h1; step(40); hs_lo = 0; step(100);
    chk("full duty", hs_lo, 0);
    overcurrent_trip <= 1'h1; step(4);
    chk("ocp", high_side_on, 1'h0);
    overcurrent_trip <= 1'h0; dropout_flag <= 1'h0;
    $display("test protection done");
    // thermal shutdown and restart through soft start
    overtemp_flag <= 1'h1; step(5);
    chk("hot gates", {high_side_on, low_side_on}, 2'h0);
    wait_state(3'h4, 3);
    overtemp_flag <= 1'h0;
    wait_state(3'h2, 10);
    chk("ramp low", ramp_ref < 10'h40, 1'h1);
    wait_state(3'h3, 1200);
    // supply lockout, then disable
    low_supply_lockout <= 1'h1; step(5);
    wait_state(3'h0, 3);
    low_supply_lockout <= 1'h0; enable_pin <= 1'h0; step(6);
    chk("dis gates", {high_side_on, low_side_on}, 2'h0);
    chk("dis bleed", discharge_on, 1'h1);
    $display("test shutdown done");
    summarize();
  end
endmodule // tb_top
